// ---- logic/rx_mac_config.sv ----
// receive configuration, overflow counters and frame checks behind an apb slave
//
// Chosen here: the APB register port.
`timescale 1ns/1ps

// saturating-free event counter with a clear that still counts a coincident event
module overflow_counter #(
    parameter int WIDTH = 36
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic count_event,
    input wire logic clear,
    // state
    output logic [WIDTH-1:0] value
);
    wire logic [WIDTH-1:0] value_next;

    // an event on the clearing cycle leaves a count of one
    assign value_next = clear ? WIDTH'(count_event) : value + WIDTH'(count_event);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value <= '0;
        end else begin
            value <= value_next;
        end
    end
endmodule : overflow_counter

// Behaviour
// [R1] count truncated frames in 36-bit split counter
// [R2] count dropped frames in second split counter
// [R3] reading upper word alone clears a counter
// [R4] preamble forward bit: strip or deliver preamble
// [R5] passthrough bit enables preamble passthrough mode
// [R6] frame control register, read-write, resets to 3
// [R7] flag error bit 3 on over-length frames
// [R8] software loads station address word layout
// [R9] filter unicast by station address unless accept-all
// [R10] counters step by one; reserved bits read zero
module rx_mac_config #(
    parameter int ADDR_W = 16
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // overflow events from the receive buffer
    input wire logic trunc_frame_event,
    input wire logic drop_frame_event,
    // frame check request
    input wire logic frame_end,
    input wire logic [rx_mac_regs_pkg::LEN_W-1:0] frame_length,
    input wire logic [rx_mac_regs_pkg::MAC_ADDR_W-1:0] frame_dest_addr,
    // frame check result
    output logic check_valid,
    output logic [rx_mac_regs_pkg::ERR_W-1:0] receive_error_flags,
    output logic frame_accept,
    // datapath controls
    output logic preamble_forward,
    output logic passthrough_en,
    output logic [31:0] frame_ctrl,
    // interrupt
    output logic irq
);
    import rx_mac_regs_pkg::*;

    if (ADDR_W < IDX_W + 2) begin : g_addr_check
        $error("ADDR_W too narrow for the register map");
    end

    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    logic preamble_fwd_reg;
    logic passthrough_reg;
    logic [31:0] frame_ctrl_reg;
    logic [LEN_W-1:0] max_len_reg;
    logic [31:0] addr_low_reg;
    logic [ADDR_HIGH_W-1:0] addr_high_reg;
    logic [EV_W-1:0] irq_status_reg;
    logic [EV_W-1:0] irq_enable_reg;
    logic irq_reg;
    logic check_valid_reg;
    logic [ERR_W-1:0] err_flags_reg;
    logic accept_reg;
    logic [CNT_W-1:0] trunc_count;
    logic [CNT_W-1:0] drop_count;

    // address decode
    wire logic [IDX_W-1:0] idx = paddr[IDX_W+1:2];
    wire logic sel_trunc_low = (idx == IDX_TRUNC_LOW);
    wire logic sel_trunc_high = (idx == IDX_TRUNC_HIGH);
    wire logic sel_drop_low = (idx == IDX_DROP_LOW);
    wire logic sel_drop_high = (idx == IDX_DROP_HIGH);
    wire logic sel_pre_fwd = (idx == IDX_PREAMBLE_FWD);
    wire logic sel_pass = (idx == IDX_PASSTHROUGH);
    wire logic sel_frame_ctrl = (idx == IDX_FRAME_CTRL);
    wire logic sel_max_len = (idx == IDX_MAX_LEN);
    wire logic sel_addr_low = (idx == IDX_ADDR_LOW);
    wire logic sel_addr_high = (idx == IDX_ADDR_HIGH);
    wire logic sel_irq_status = (idx == IDX_IRQ_STATUS);
    wire logic sel_irq_clear = (idx == IDX_IRQ_CLEAR);
    wire logic sel_irq_enable = (idx == IDX_IRQ_ENABLE);
    // with the narrowest bus there are no index bits above the map to check
    wire logic upper_zero;
    if (ADDR_W > IDX_W + 2) begin : g_upper_bits
        assign upper_zero = (paddr[ADDR_W-1:IDX_W+2] == '0);
    end else begin : g_no_upper_bits
        assign upper_zero = 1'b1;
    end
    wire logic mapped = upper_zero & (sel_trunc_low | sel_trunc_high | sel_drop_low
        | sel_drop_high | sel_pre_fwd | sel_pass | sel_frame_ctrl | sel_max_len
        | sel_addr_low | sel_addr_high | sel_irq_status | sel_irq_clear | sel_irq_enable);

    // first access cycle samples data; the second completes the transfer
    wire logic access_start = psel & penable & ~pready_reg;
    wire logic access_done = psel & penable & pready_reg;
    wire logic wr_en = access_done & pwrite & ~pslverr_reg;
    wire logic rd_start = access_start & ~pwrite & mapped;

    // read data mux; unused and reserved bits read zero
    logic [31:0] rd_data;
    always_comb begin
        rd_data = '0;
        if (sel_trunc_low) begin
            rd_data = trunc_count[CNT_LOW_W-1:0]; // see [R1]
        end else if (sel_trunc_high) begin
            rd_data[CNT_HIGH_W-1:0] = trunc_count[CNT_W-1:CNT_LOW_W]; // see [R1] see [R10]
        end else if (sel_drop_low) begin
            rd_data = drop_count[CNT_LOW_W-1:0]; // see [R2]
        end else if (sel_drop_high) begin
            rd_data[CNT_HIGH_W-1:0] = drop_count[CNT_W-1:CNT_LOW_W]; // see [R2] see [R10]
        end else if (sel_pre_fwd) begin
            rd_data[0] = preamble_fwd_reg;
        end else if (sel_pass) begin
            rd_data[0] = passthrough_reg;
        end else if (sel_frame_ctrl) begin
            rd_data = frame_ctrl_reg;
        end else if (sel_max_len) begin
            rd_data[LEN_W-1:0] = max_len_reg;
        end else if (sel_addr_low) begin
            rd_data = addr_low_reg;
        end else if (sel_addr_high) begin
            rd_data[ADDR_HIGH_W-1:0] = addr_high_reg;
        end else if (sel_irq_status) begin
            rd_data[EV_W-1:0] = irq_status_reg;
        end else if (sel_irq_enable) begin
            rd_data[EV_W-1:0] = irq_enable_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= '0;
        end else begin
            pready_reg <= access_start;
            pslverr_reg <= access_start & ~mapped;
            if (access_start) begin
                prdata_reg <= mapped ? rd_data : '0;
            end
        end
    end

    // counters clear on the cycle their upper word is captured for reading
    wire logic clr_trunc = rd_start & sel_trunc_high; // see [R3]
    wire logic clr_drop = rd_start & sel_drop_high; // see [R3]

    overflow_counter #(.WIDTH(CNT_W)) u_trunc_count (
        .pclk(pclk),
        .presetn(presetn),
        .count_event(trunc_frame_event), // see [R1] see [R10]
        .clear(clr_trunc),
        .value(trunc_count)
    );

    overflow_counter #(.WIDTH(CNT_W)) u_drop_count (
        .pclk(pclk),
        .presetn(presetn),
        .count_event(drop_frame_event), // see [R2] see [R10]
        .clear(clr_drop),
        .value(drop_count)
    );

    // control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            preamble_fwd_reg <= 1'b0;
            passthrough_reg <= 1'b0;
            frame_ctrl_reg <= FRAME_CTRL_RESET;
            max_len_reg <= MAX_LEN_RESET;
            addr_low_reg <= '0;
            addr_high_reg <= '0;
            irq_enable_reg <= '0;
        end else if (wr_en) begin
            if (sel_pre_fwd) begin
                preamble_fwd_reg <= pwdata[0]; // see [R4]
            end
            if (sel_pass) begin
                passthrough_reg <= pwdata[0]; // see [R5]
            end
            if (sel_frame_ctrl) begin
                frame_ctrl_reg <= pwdata; // see [R6]
            end
            if (sel_max_len) begin
                max_len_reg <= pwdata[LEN_W-1:0]; // see [R7]
            end
            if (sel_addr_low) begin
                addr_low_reg <= pwdata; // see [R8]
            end
            if (sel_addr_high) begin
                addr_high_reg <= pwdata[ADDR_HIGH_W-1:0]; // see [R8]
            end
            if (sel_irq_enable) begin
                irq_enable_reg <= pwdata[EV_W-1:0];
            end
        end
    end

    // frame checks
    wire logic [MAC_ADDR_W-1:0] station_addr = {addr_high_reg, addr_low_reg};
    wire logic is_unicast = ~frame_dest_addr[GROUP_BIT];
    wire logic accept_all_ucast = frame_ctrl_reg[ALLUCAST_BIT];
    wire logic oversize = frame_length > max_len_reg; // see [R7]
    wire logic addr_miss = is_unicast & ~accept_all_ucast
        & (frame_dest_addr != station_addr); // see [R9]
    wire logic oversize_event = frame_end & oversize;
    wire logic miss_event = frame_end & addr_miss;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            check_valid_reg <= 1'b0;
            err_flags_reg <= '0;
            accept_reg <= 1'b0;
        end else begin
            check_valid_reg <= frame_end;
            if (frame_end) begin
                err_flags_reg <= '0;
                err_flags_reg[ERR_OVERSIZE_BIT] <= oversize; // see [R7]
                accept_reg <= ~addr_miss; // see [R9]
            end
        end
    end

    // interrupt status: a new event wins over a clear in the same cycle
    wire logic [EV_W-1:0] events = {miss_event, oversize_event, drop_frame_event,
        trunc_frame_event};
    wire logic [EV_W-1:0] clr_mask = (wr_en & sel_irq_clear) ? pwdata[EV_W-1:0] : '0;
    wire logic [EV_W-1:0] irq_status_next = (irq_status_reg & ~clr_mask) | events;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            irq_status_reg <= irq_status_next;
            irq_reg <= |(irq_status_next & irq_enable_reg);
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign check_valid = check_valid_reg;
    assign receive_error_flags = err_flags_reg;
    assign frame_accept = accept_reg;
    assign preamble_forward = preamble_fwd_reg;
    assign passthrough_en = passthrough_reg;
    assign frame_ctrl = frame_ctrl_reg;
    assign irq = irq_reg;

    // checks
    a_trunc_count_step: assert property (@(posedge pclk) disable iff (!presetn) // see [R1]
        trunc_frame_event && !clr_trunc |=> trunc_count == $past(trunc_count) + 36'h1)
        else $error("truncated frame counter did not step by one");

    a_drop_count_step: assert property (@(posedge pclk) disable iff (!presetn) // see [R2]
        drop_frame_event && !clr_drop |=> drop_count == $past(drop_count) + 36'h1)
        else $error("dropped frame counter did not step by one");

    a_high_read_clears: assert property (@(posedge pclk) disable iff (!presetn) // see [R3]
        rd_start && sel_trunc_high && !trunc_frame_event ##1 access_done
        |-> trunc_count == '0 && prdata[CNT_HIGH_W-1:0] == $past(trunc_count[CNT_W-1:CNT_LOW_W]))
        else $error("upper word read did not clear the counter");

    a_low_read_keeps: assert property (@(posedge pclk) disable iff (!presetn) // see [R3]
        rd_start && sel_drop_low && !drop_frame_event |=> $stable(drop_count))
        else $error("lower word read changed the counter");

    a_preamble_fwd_write: assert property (@(posedge pclk) disable iff (!presetn) // see [R4]
        wr_en && sel_pre_fwd |=> preamble_forward == $past(pwdata[0]))
        else $error("preamble forward bit not written");

    a_passthrough_write: assert property (@(posedge pclk) disable iff (!presetn) // see [R5]
        wr_en && sel_pass |=> passthrough_en == $past(pwdata[0]) ##1 $stable(passthrough_en))
        else $error("passthrough bit not written or not held");

    a_frame_ctrl_write: assert property (@(posedge pclk) disable iff (!presetn) // see [R6]
        wr_en && sel_frame_ctrl |=> frame_ctrl == $past(pwdata))
        else $error("frame control register not written");

    a_oversize_flag: assert property (@(posedge pclk) disable iff (!presetn) // see [R7]
        frame_end |=> check_valid
        && receive_error_flags[ERR_OVERSIZE_BIT] == $past(frame_length > max_len_reg))
        else $error("oversize error flag wrong");

    a_unicast_filter: assert property (@(posedge pclk) disable iff (!presetn) // see [R9]
        frame_end && !frame_dest_addr[GROUP_BIT] && !frame_ctrl[ALLUCAST_BIT]
        && frame_dest_addr != {addr_high_reg, addr_low_reg} |=> !frame_accept)
        else $error("unicast frame with foreign address accepted");

    a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn) // see [R10]
        rd_start && (sel_drop_high || sel_max_len || sel_pass) |=> prdata[31:16] == 16'h0)
        else $error("reserved bits read nonzero");
endmodule : rx_mac_config

// ---- include/rx_mac_regs_pkg.sv ----
// register map, field layout and reset values of the receive configuration bank
package rx_mac_regs_pkg;
    // register indices; the byte address is four times the index
    localparam int IDX_W = 14;
    localparam logic [IDX_W-1:0] IDX_TRUNC_LOW = 14'h00C0;
    localparam logic [IDX_W-1:0] IDX_TRUNC_HIGH = 14'h00C1;
    localparam logic [IDX_W-1:0] IDX_DROP_LOW = 14'h00C2;
    localparam logic [IDX_W-1:0] IDX_DROP_HIGH = 14'h00C3;
    localparam logic [IDX_W-1:0] IDX_PREAMBLE_FWD = 14'h0100;
    localparam logic [IDX_W-1:0] IDX_PASSTHROUGH = 14'h0140;
    localparam logic [IDX_W-1:0] IDX_FRAME_CTRL = 14'h0800;
    localparam logic [IDX_W-1:0] IDX_MAX_LEN = 14'h0801;
    localparam logic [IDX_W-1:0] IDX_ADDR_LOW = 14'h0802;
    localparam logic [IDX_W-1:0] IDX_ADDR_HIGH = 14'h0803;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 14'h0900;
    localparam logic [IDX_W-1:0] IDX_IRQ_CLEAR = 14'h0901;
    localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE = 14'h0902;

    // counter layout
    localparam int CNT_W = 36;
    localparam int CNT_LOW_W = 32;
    localparam int CNT_HIGH_W = 4;

    // reset values
    localparam logic [31:0] FRAME_CTRL_RESET = 32'h0000_0003;
    localparam logic [15:0] MAX_LEN_RESET = 16'h05EE;

    // field positions
    localparam int ALLUCAST_BIT = 0;
    localparam int LEN_W = 16;
    localparam int ADDR_HIGH_W = 16;
    localparam int MAC_ADDR_W = 48;
    localparam int GROUP_BIT = 40;
    localparam int ERR_W = 6;
    localparam int ERR_OVERSIZE_BIT = 3;

    // event bits of the interrupt status, clear and enable registers
    localparam int EV_W = 4;
    localparam int EV_TRUNC = 0;
    localparam int EV_DROP = 1;
    localparam int EV_OVERSIZE = 2;
    localparam int EV_ADDR_MISS = 3;
endpackage : rx_mac_regs_pkg

// ---- test/rx_mac_config_test.sv ----
// self-checking testbench of the receive configuration bank
`timescale 1ns/1ps
module rx_mac_config_test;
    import rx_mac_regs_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic trunc_frame_event = 1'b0;
    logic drop_frame_event = 1'b0;
    logic frame_end = 1'b0;
    logic [LEN_W-1:0] frame_length = 16'h0000;
    logic [MAC_ADDR_W-1:0] frame_dest_addr = 48'h0000_0000_0000;
    logic check_valid;
    logic [ERR_W-1:0] receive_error_flags;
    logic frame_accept;
    logic preamble_forward;
    logic passthrough_en;
    logic [31:0] frame_ctrl;
    logic irq;
    int num_errors = 0;
    int tests_run = 0;

    rx_mac_config #(.ADDR_W(16)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .trunc_frame_event(trunc_frame_event),
        .drop_frame_event(drop_frame_event), .frame_end(frame_end),
        .frame_length(frame_length), .frame_dest_addr(frame_dest_addr),
        .check_valid(check_valid), .receive_error_flags(receive_error_flags),
        .frame_accept(frame_accept), .preamble_forward(preamble_forward),
        .passthrough_en(passthrough_en), .frame_ctrl(frame_ctrl), .irq(irq));

    always #25 pclk = ~pclk;

    task end_sim;
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim

    task chk(input logic [47:0] got, input logic [47:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer; request held until pready is seen high
    task apb(input logic w, input logic [13:0] idx, input logic [31:0] d,
             output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            num_errors++;
            $display("[FAIL] t=%0t apb timeout got=%h exp=%h", $time, pready, 1'b1);
            end_sim;
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rd(input logic [13:0] idx, input logic [31:0] exp, input logic exp_err);
        logic [31:0] q;
        logic e;
        apb(1'b0, idx, 32'h0000_0000, q, e);
        chk({15'h0000, e, q}, {15'h0000, exp_err, exp});
    endtask : rd

    task wr(input logic [13:0] idx, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, idx, d, q, e);
    endtask : wr

    task frame(input logic [15:0] len, input logic [47:0] dest, input logic [5:0] flags,
               input logic acc);
        @(posedge pclk);
        frame_end <= 1'b1;
        frame_length <= len;
        frame_dest_addr <= dest;
        @(posedge pclk);
        frame_end <= 1'b0;
        @(posedge pclk);
        chk({40'h0, check_valid, frame_accept, receive_error_flags}, {40'h0, 1'b1, acc, flags});
    endtask : frame

    task test_reset;
        chk({14'h0, frame_ctrl, preamble_forward, passthrough_en}, 48'h0000_0000_000C);
        chk({39'h0, irq, check_valid, frame_accept, receive_error_flags}, 48'h0);
        rd(IDX_TRUNC_LOW, 32'h0, 1'b0);
        rd(IDX_DROP_LOW, 32'h0, 1'b0);
        rd(IDX_PREAMBLE_FWD, 32'h0, 1'b0);
        rd(IDX_PASSTHROUGH, 32'h0, 1'b0);
        rd(IDX_FRAME_CTRL, 32'h3, 1'b0);
        rd(IDX_MAX_LEN, 32'h5EE, 1'b0);
        rd(IDX_ADDR_LOW, 32'h0, 1'b0);
        rd(IDX_ADDR_HIGH, 32'h0, 1'b0);
        rd(IDX_IRQ_ENABLE, 32'h0, 1'b0);
        rd(14'h00C4, 32'h0, 1'b1);
        $display("test reset finished");
    endtask : test_reset

    task test_counters;
        wr(IDX_TRUNC_LOW, 32'hFFFF_FFFF);
        @(posedge pclk);
        trunc_frame_event <= 1'b1;
        repeat (3) @(posedge pclk);
        trunc_frame_event <= 1'b0;
        drop_frame_event <= 1'b1;
        repeat (2) @(posedge pclk);
        drop_frame_event <= 1'b0;
        rd(IDX_TRUNC_LOW, 32'h3, 1'b0);
        rd(IDX_TRUNC_LOW, 32'h3, 1'b0);
        rd(IDX_TRUNC_HIGH, 32'h0, 1'b0);
        rd(IDX_TRUNC_LOW, 32'h0, 1'b0);
        rd(IDX_DROP_LOW, 32'h2, 1'b0);
        rd(IDX_DROP_HIGH, 32'h0, 1'b0);
        rd(IDX_DROP_LOW, 32'h0, 1'b0);
        $display("test counters finished");
    endtask : test_counters

    task test_controls;
        wr(IDX_PREAMBLE_FWD, 32'hFFFF_FFFF);
        rd(IDX_PREAMBLE_FWD, 32'h1, 1'b0);
        chk({47'h0, preamble_forward}, 48'h1);
        wr(IDX_PASSTHROUGH, 32'hFFFF_FFFF);
        rd(IDX_PASSTHROUGH, 32'h1, 1'b0);
        chk({47'h0, passthrough_en}, 48'h1);
        wr(IDX_PASSTHROUGH, 32'h0);
        // the write lands at the edge that ends the transfer; look one edge later
        @(posedge pclk);
        chk({47'h0, passthrough_en}, 48'h0);
        frame(16'd1518, 48'h1, 6'h00, 1'b1);
        frame(16'd1519, 48'h1, 6'h08, 1'b1);
        wr(IDX_MAX_LEN, 32'hFFFF_0040);
        rd(IDX_MAX_LEN, 32'h40, 1'b0);
        frame(16'h0041, 48'h1, 6'h08, 1'b1);
        frame(16'h0040, 48'h1, 6'h00, 1'b1);
        $display("test controls finished");
    endtask : test_controls

    task test_filter;
        wr(IDX_ADDR_LOW, 32'h2317_4ACB);
        wr(IDX_ADDR_HIGH, 32'hFFFF_001C);
        rd(IDX_ADDR_HIGH, 32'h0000_001C, 1'b0);
        frame(16'h0040, 48'h001C_2317_4ACA, 6'h00, 1'b1);
        wr(IDX_FRAME_CTRL, 32'h0000_0002);
        rd(IDX_FRAME_CTRL, 32'h2, 1'b0);
        chk({16'h0, frame_ctrl}, 48'h2);
        frame(16'h0040, 48'h001C_2317_4ACB, 6'h00, 1'b1);
        frame(16'h0040, 48'h001C_2317_4ACA, 6'h00, 1'b0);
        frame(16'h0040, 48'h011C_2317_4ACA, 6'h00, 1'b1);
        $display("test filter finished");
    endtask : test_filter

    task test_irq;
        wr(IDX_IRQ_CLEAR, 32'hF);
        rd(IDX_IRQ_STATUS, 32'h0, 1'b0);
        // matching station address, so only the oversize event is raised
        frame(16'h0041, 48'h001C_2317_4ACB, 6'h08, 1'b1);
        rd(IDX_IRQ_STATUS, 32'h4, 1'b0);
        chk({47'h0, irq}, 48'h0);
        wr(IDX_IRQ_ENABLE, 32'h4);
        repeat (2) @(posedge pclk);
        chk({47'h0, irq}, 48'h1);
        wr(IDX_IRQ_CLEAR, 32'h4);
        repeat (2) @(posedge pclk);
        chk({47'h0, irq}, 48'h0);
        rd(IDX_IRQ_STATUS, 32'h0, 1'b0);
        $display("test irq finished");
    endtask : test_irq

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        test_reset;
        test_counters;
        test_controls;
        test_filter;
        test_irq;
        end_sim;
    end
endmodule : rx_mac_config_test
